// File: ces_selector.sv
// Event selector and counter for cache, lock, writeback and TLB events.
// Assumes event pulses arrive from same-clock pipelines, one per source per cycle.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Event 24H mask FFH counts every second-level request, code or data.
// - Event 26H low mask bits count demand loads by line state I,S,E,M.
// - Event 26H mask 0FH counts every demand data request.
// - Event 26H high mask bits count prefetch loads by line state.
// - Prefetch ownership to shared line counts as miss; prefetch read hits.
// - Event 26H mask F0H counts every prefetch request.
// - Event 26H mask FFH counts every demand and prefetch data request, not store or lock ownership.
// - Event 27H low mask bits count store ownership requests by state.
// - Event 27H mask 0FH counts every store ownership request.
// - Event 27H high mask bits count lock ownership requests by state.
// - Event 27H mask E0H counts lock hits; F0H counts all locks.
// - Event 28H low mask bits count first-level writebacks by state.
// - Event 2EH counts last-level misses with 41H, references with 4FH.
// - Event 3CH mask 00H counts core cycles while not halted.
// - Event 3CH mask 01H counts time-stamp ticks while not halted.
// - Event 49H mask 01H counts second-level TLB misses starting walks.
module ces_selector (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire ces_pkg::ces_bus_t bus,
   output logic [ces_pkg::DATA_W-1:0] rdata,
   // Second-level cache request pulses
   input wire ces_pkg::ces_l2_req_t l2_req,
   // First-level writeback pulses
   input wire ces_pkg::ces_wb_t wb,
   // Last-level cache pulses
   input wire logic llc_miss,
   input wire logic llc_ref,
   // Thread and TLB
   input wire logic thread_halted,
   input wire logic tlb_walk,
   // Selected event pulse
   output logic hit
);
   import ces_pkg::*;

   ces_sel_t sel_r;
   logic [DATA_W-1:0] cnt_r;
   logic [DATA_W-1:0] rdata_r;
   logic stamp_tick;
   logic hit_nxt;
   ces_line_t eff_state;
   logic data_req;
   logic wr_sel;
   logic wr_cnt;

   // Picks the mask bit of one line state
   function automatic logic state_sel(input logic [3:0] nib, input ces_line_t st);
      state_sel = nib[st];
   endfunction

   ces_tick_div ces_tick_div_i (
      .clk(clk),
      .rst(rst),
      .tick(stamp_tick)
   );

   // Write decode
   always_comb begin
      wr_sel = 1'b0;
      wr_cnt = 1'b0;
      if (bus.wr && bus.addr == OFS_SEL) begin
         wr_sel = 1'b1;
      end else if (bus.wr && bus.addr == OFS_COUNT) begin
         wr_cnt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_r <= ces_sel_t'(SEL_RST);
      end else if (wr_sel) begin
         sel_r <= ces_sel_t'(bus.wdata[SEL_W-1:0]);
      end
   end

   assign data_req = l2_req.valid && !l2_req.is_code;

   always_comb begin
      eff_state = l2_req.state;
      if (l2_req.kind == KIND_PREFETCH_LOAD && l2_req.pf_own
            && l2_req.state == LINE_S) begin
         eff_state = LINE_I;
      end
   end

   // Event decode, one pulse per event at most
   always_comb begin
      hit_nxt = 1'b0;
      case (sel_r.evt)
         EVT_L2_ALL: begin
            hit_nxt = (sel_r.mask == MASK_ALL) && l2_req.valid;
         end
         EVT_L2_DATA: begin
            if (l2_req.kind == KIND_DEMAND_LOAD) begin
               hit_nxt = data_req && state_sel(sel_r.mask[3:0], eff_state);
            end else if (l2_req.kind == KIND_PREFETCH_LOAD) begin
               hit_nxt = data_req && state_sel(sel_r.mask[7:4], eff_state);
            end
         end
         EVT_L2_WRITE: begin
            if (l2_req.kind == KIND_STORE_OWN) begin
               hit_nxt = data_req && state_sel(sel_r.mask[3:0], l2_req.state);
            end else if (l2_req.kind == KIND_LOCK_OWN) begin
               hit_nxt = data_req && state_sel(sel_r.mask[7:4], l2_req.state);
            end
         end
         EVT_WB: begin
            hit_nxt = wb.valid && sel_r.mask[7:4] == NIB_NONE
               && state_sel(sel_r.mask[3:0], wb.state);
         end
         EVT_LLC: begin
            if (sel_r.mask == MASK_LLC_MISS) begin
               hit_nxt = llc_miss;
            end else if (sel_r.mask == MASK_LLC_REF) begin
               hit_nxt = llc_ref;
            end
         end
         EVT_UNHALT: begin
            if (sel_r.mask == MASK_THREAD) begin
               hit_nxt = !thread_halted;
            end else if (sel_r.mask == MASK_REF) begin
               hit_nxt = stamp_tick && !thread_halted;
            end
         end
         EVT_TLB: begin
            hit_nxt = (sel_r.mask == MASK_WALK) && tlb_walk;
         end
         default: begin
            hit_nxt = 1'b0;
         end
      endcase
   end

   assign hit = hit_nxt;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= COUNT_RST;
      end else if (wr_cnt) begin
         cnt_r <= bus.wdata;
      end else if (hit_nxt) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Read data stand one cycle only
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= RD_IDLE;
      end else if (!bus.rd) begin
         rdata_r <= RD_IDLE;
      end else if (bus.addr == OFS_SEL) begin
         rdata_r <= {{(DATA_W-SEL_W){1'b0}}, sel_r};
      end else if (bus.addr == OFS_COUNT) begin
         rdata_r <= cnt_r;
      end else if (bus.addr == OFS_STATUS) begin
         rdata_r <= {{(DATA_W-2){1'b0}}, thread_halted, hit_nxt};
      end else begin
         rdata_r <= RD_IDLE;
      end
   end

   assign rdata = rdata_r;

   // Checks on the counter against its cause

   property p_l2_all;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_ALL && sel_r.mask == MASK_ALL && l2_req.valid && !wr_cnt
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_l2_all: assert property (p_l2_all) else $error("request not counted");

   property p_dem_miss;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == 8'h01 && data_req && !wr_cnt
      && l2_req.kind == KIND_DEMAND_LOAD && l2_req.state != LINE_I
      |=> cnt_r == $past(cnt_r);
   endproperty
   a_dem_miss: assert property (p_dem_miss) else $error("demand hit counted as miss");

   property p_dem_all;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == 8'h0f && data_req && !wr_cnt
      && l2_req.kind == KIND_DEMAND_LOAD
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_dem_all: assert property (p_dem_all) else $error("demand load not counted");

   property p_pf_mod;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == 8'h80 && data_req && !wr_cnt
      && l2_req.kind == KIND_PREFETCH_LOAD && l2_req.state == LINE_M
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_pf_mod: assert property (p_pf_mod) else $error("modified prefetch missed");

   property p_pf_own_s;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == 8'h20 && data_req && !wr_cnt
      && l2_req.kind == KIND_PREFETCH_LOAD && l2_req.pf_own
      && l2_req.state == LINE_S
      |=> cnt_r == $past(cnt_r);
   endproperty
   a_pf_own_s: assert property (p_pf_own_s) else $error("shared ownership prefetch hit");

   property p_pf_rd_s;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == 8'h20 && data_req && !wr_cnt
      && l2_req.kind == KIND_PREFETCH_LOAD && !l2_req.pf_own
      && l2_req.state == LINE_S
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_pf_rd_s: assert property (p_pf_rd_s) else $error("shared prefetch read missed");

   property p_pf_all;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == 8'hf0 && data_req && !wr_cnt
      && l2_req.kind == KIND_PREFETCH_LOAD
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_pf_all: assert property (p_pf_all) else $error("prefetch not counted");

   property p_data_any;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == MASK_ALL && data_req && !wr_cnt
      && (l2_req.kind == KIND_DEMAND_LOAD || l2_req.kind == KIND_PREFETCH_LOAD)
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_data_any: assert property (p_data_any) else $error("data request not counted");

   property p_code_data;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_DATA && sel_r.mask == MASK_ALL && l2_req.valid
      && l2_req.is_code && !wr_cnt
      |=> cnt_r == $past(cnt_r);
   endproperty
   a_code_data: assert property (p_code_data) else $error("code request counted as data");

   property p_st_s;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_WRITE && sel_r.mask == 8'h02 && data_req && !wr_cnt
      && l2_req.kind == KIND_STORE_OWN
      |=> cnt_r == $past(cnt_r) + ($past(l2_req.state) == LINE_S);
   endproperty
   a_st_s: assert property (p_st_s) else $error("store shared count wrong");

   property p_st_all;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_WRITE && sel_r.mask == 8'h0f && data_req && !wr_cnt
      && l2_req.kind == KIND_STORE_OWN
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_st_all: assert property (p_st_all) else $error("store ownership not counted");

   property p_lock_e;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_WRITE && sel_r.mask == 8'h40 && data_req && !wr_cnt
      && l2_req.kind == KIND_LOCK_OWN
      |=> cnt_r == $past(cnt_r) + ($past(l2_req.state) == LINE_E);
   endproperty
   a_lock_e: assert property (p_lock_e) else $error("lock exclusive count wrong");

   property p_lock_hit;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_WRITE && sel_r.mask == 8'he0 && data_req && !wr_cnt
      && l2_req.kind == KIND_LOCK_OWN
      |=> cnt_r == $past(cnt_r) + ($past(l2_req.state) != LINE_I);
   endproperty
   a_lock_hit: assert property (p_lock_hit) else $error("lock hit count wrong");

   property p_lock_all;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_L2_WRITE && sel_r.mask == 8'hf0 && data_req && !wr_cnt
      && l2_req.kind == KIND_LOCK_OWN
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_lock_all: assert property (p_lock_all) else $error("lock ownership not counted");

   property p_wb_all;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_WB && sel_r.mask == 8'h0f && wb.valid && !wr_cnt
      |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_wb_all: assert property (p_wb_all) else $error("writeback not counted");

   property p_llc;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_LLC && sel_r.mask == MASK_LLC_MISS && !wr_cnt
      |=> cnt_r == $past(cnt_r) + $past(llc_miss);
   endproperty
   a_llc: assert property (p_llc) else $error("last level miss count wrong");

   property p_thread;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_UNHALT && sel_r.mask == MASK_THREAD && !wr_cnt
      |=> cnt_r == $past(cnt_r) + !$past(thread_halted);
   endproperty
   a_thread: assert property (p_thread) else $error("unhalted cycle count wrong");

   property p_ref;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_UNHALT && sel_r.mask == MASK_REF && !wr_cnt
      && (thread_halted || !stamp_tick)
      |=> cnt_r == $past(cnt_r);
   endproperty
   a_ref: assert property (p_ref) else $error("reference cycle off rate");

   property p_walk;
      @(posedge clk) disable iff (rst)
      sel_r.evt == EVT_TLB && sel_r.mask == MASK_WALK && !wr_cnt
      |=> cnt_r == $past(cnt_r) + $past(tlb_walk);
   endproperty
   a_walk: assert property (p_walk) else $error("page walk count wrong");

   property p_once;
      @(posedge clk) disable iff (rst)
      !wr_cnt |=> cnt_r - $past(cnt_r) <= 32'h0000_0001;
   endproperty
   a_once: assert property (p_once) else $error("counter stepped twice");

   property p_unknown;
      @(posedge clk) disable iff (rst)
      sel_r.evt == 8'h00 && !wr_cnt ##1 sel_r.evt == 8'h00 && !wr_cnt
      |=> cnt_r == $past(cnt_r, 2);
   endproperty
   a_unknown: assert property (p_unknown) else $error("idle selection counted");

endmodule // ces_selector

`default_nettype wire

// File: ces_pkg.sv
// Constants and carrier types for the cache event selector.
// Assumes a single 200 MHz core clock and same-clock event sources.
`default_nettype none

package ces_pkg;

   // Register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int SEL_W = 16;
   localparam logic [ADDR_W-1:0] OFS_SEL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
   localparam logic [SEL_W-1:0] SEL_RST = 16'h0000;
   localparam logic [DATA_W-1:0] COUNT_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RD_IDLE = 32'h0000_0000;

   // Event numbers
   localparam logic [7:0] EVT_L2_ALL = 8'h24;
   localparam logic [7:0] EVT_L2_DATA = 8'h26;
   localparam logic [7:0] EVT_L2_WRITE = 8'h27;
   localparam logic [7:0] EVT_WB = 8'h28;
   localparam logic [7:0] EVT_LLC = 8'h2e;
   localparam logic [7:0] EVT_UNHALT = 8'h3c;
   localparam logic [7:0] EVT_TLB = 8'h49;

   // Unit masks with fixed meaning
   localparam logic [7:0] MASK_ALL = 8'hff;
   localparam logic [7:0] MASK_LLC_MISS = 8'h41;
   localparam logic [7:0] MASK_LLC_REF = 8'h4f;
   localparam logic [7:0] MASK_THREAD = 8'h00;
   localparam logic [7:0] MASK_REF = 8'h01;
   localparam logic [7:0] MASK_WALK = 8'h01;
   localparam logic [3:0] NIB_NONE = 4'h0;

   // Time-stamp rate against the core clock
   localparam int CLK_PERIOD_NS = 5;
   localparam int STAMP_PERIOD_NS = 10;
   localparam int STAMP_DIV_RAW = STAMP_PERIOD_NS / CLK_PERIOD_NS;
   localparam int STAMP_DIV = (STAMP_DIV_RAW < 1) ? 1 : STAMP_DIV_RAW;
   localparam int DIV_W = 4;

   typedef enum logic [1:0] {
      LINE_I = 2'h0,
      LINE_S = 2'h1,
      LINE_E = 2'h2,
      LINE_M = 2'h3
   } ces_line_t;

   typedef enum logic [1:0] {
      KIND_DEMAND_LOAD = 2'h0,
      KIND_PREFETCH_LOAD = 2'h1,
      KIND_STORE_OWN = 2'h2,
      KIND_LOCK_OWN = 2'h3
   } ces_kind_t;

   typedef struct packed {
      logic valid;
      logic is_code;
      ces_kind_t kind;
      logic pf_own;
      ces_line_t state;
   } ces_l2_req_t;

   typedef struct packed {
      logic valid;
      ces_line_t state;
   } ces_wb_t;

   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] evt;
   } ces_sel_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ces_bus_t;

endpackage

`default_nettype wire

// File: ces_tick_div.sv
// Divider making the time-stamp rate as a one-cycle enable.
// Assumes a synchronous active-high reset on the core clock.
`timescale 1ns/100ps
`default_nettype none

module ces_tick_div (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Enable pulse out
   output logic tick
);
   import ces_pkg::*;

   localparam logic [DIV_W-1:0] LAST = DIV_W'(STAMP_DIV - 1);
   localparam logic [DIV_W-1:0] ZERO = 4'h0;

   logic [DIV_W-1:0] div_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= ZERO;
      end else if (div_r == LAST) begin
         div_r <= ZERO;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   assign tick = (div_r == LAST);

endmodule // ces_tick_div

`default_nettype wire

// File: ces_src.sv
// Behavioural model of the cache and TLB pipelines feeding the selector.
// Assumes the bench asks for one pulse per cycle through go and src.
`timescale 1ns/100ps
`default_nettype none

module ces_src (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bench command
   input wire logic go,
   input wire logic [2:0] src,
   input wire ces_pkg::ces_l2_req_t ev,
   input wire logic halt_in,
   // Event pulses
   output var ces_pkg::ces_l2_req_t l2_req,
   output var ces_pkg::ces_wb_t wb,
   output var logic llc_miss,
   output var logic llc_ref,
   output var logic tlb_walk,
   output var logic thread_halted
);
   import ces_pkg::*;
   logic [4:0] fire;
   ces_l2_req_t req_c;

   assign fire = (go && !rst) ? (5'h01 << src) : 5'h00;

   always_comb begin
      req_c = ev;
      if (ev.kind == KIND_STORE_OWN) begin
         req_c.pf_own = 1'b0;
      end
   end

   // Idle fields keep changing so stale values never look valid
   always @(posedge clk) begin
      if (rst) begin
         l2_req <= '0;
         wb <= '0;
      end else begin
         l2_req <= fire[0] ? req_c : {1'b0, ~l2_req[5:0]};
         wb <= fire[1] ? {1'b1, ev.state} : {1'b0, ~wb[1:0]};
      end
      llc_miss <= fire[2];
      llc_ref <= fire[3];
      tlb_walk <= fire[4];
      thread_halted <= rst | halt_in;
   end
endmodule // ces_src

`default_nettype wire

// File: ces_selector_tb.sv
// Self-checking bench for the cache event selector.
// Assumes the pipeline model in ces_src and the register map of the package.
`timescale 1ns/100ps
`default_nettype none

module ces_selector_tb;
   import ces_pkg::*;
   // Entry: event, mask, source, kind, state, flags {pf_own, code, expected}
   localparam logic [31:0] TBL [0:37] = '{
      32'h24ff_0003, 32'h24ff_0201, 32'h2601_0001, 32'h2601_0010,
      32'h2608_0031, 32'h2604_0021, 32'h260f_0011, 32'h260f_0110,
      32'h2610_0101, 32'h2680_0131, 32'h2640_0020, 32'h2620_0114,
      32'h2610_0115, 32'h2620_0111, 32'h26f0_0121, 32'h26ff_0031,
      32'h26ff_0002, 32'h2701_0201, 32'h2702_0211, 32'h2708_0220,
      32'h2708_0231, 32'h270f_0221, 32'h2710_0301, 32'h2780_0331,
      32'h27e0_0300, 32'h27e0_0311, 32'h27f0_0301, 32'h2802_1011,
      32'h280f_1031, 32'h2801_1030, 32'h2812_1010, 32'h2e41_2001,
      32'h2e41_3000, 32'h2e4f_3001, 32'h4901_4001, 32'h4902_4000,
      32'h2401_0000, 32'h55ff_0000};
   logic clk, rst, go, halt_in, hit;
   logic llc_miss, llc_ref, tlb_walk, thread_halted;
   logic [2:0] src;
   logic [DATA_W-1:0] rdata, q;
   ces_l2_req_t ev, l2_req;
   ces_wb_t wb;
   ces_bus_t bus;
   int errors = 0;
   int samples_checked = 0;

   ces_src ces_src_i (.clk(clk), .rst(rst), .go(go), .src(src), .ev(ev), .halt_in(halt_in),
      .l2_req(l2_req), .wb(wb), .llc_miss(llc_miss), .llc_ref(llc_ref),
      .tlb_walk(tlb_walk), .thread_halted(thread_halted));
   ces_selector ces_selector_i (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .l2_req(l2_req), .wb(wb), .llc_miss(llc_miss), .llc_ref(llc_ref),
      .thread_halted(thread_halted), .tlb_walk(tlb_walk), .hit(hit));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic final_report;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata;
   endtask

   task automatic send(input logic [31:0] e, output logic h);
      @(posedge clk);
      go <= 1'b1;
      src <= e[14:12];
      ev <= '{valid: 1'b1, is_code: e[1], kind: ces_kind_t'(e[9:8]), pf_own: e[2],
         state: ces_line_t'(e[5:4])};
      @(posedge clk);
      go <= 1'b0;
      #1 h = hit;
   endtask

   task automatic run_regs;
      rd(OFS_SEL, q);
      chk(q, {16'h0000, SEL_RST});
      rd(OFS_COUNT, q);
      chk(q, COUNT_RST);
      wr(OFS_SEL, 32'hffff_ff24);
      rd(OFS_SEL, q);
      chk(q, 32'h0000_ff24);
      wr(OFS_COUNT, 32'h0000_1234);
      rd(OFS_COUNT, q);
      chk(q, 32'h0000_1234);
      @(posedge clk);
      #1 chk(rdata, RD_IDLE);
      rd(4'hc, q);
      chk(q, RD_IDLE);
   endtask

   task automatic run_table;
      logic [31:0] e;
      logic h;
      for (int i = 0; i < 38; i++) begin
         e = TBL[i];
         wr(OFS_SEL, {16'h0000, e[23:16], e[31:24]});
         wr(OFS_COUNT, COUNT_RST);
         send(e, h);
         chk({31'h0, h}, {31'h0, e[0]});
         rd(OFS_COUNT, q);
         chk(q, {31'h0, e[0]});
      end
   endtask

   // Back-to-back demand loads through all four line states
   task automatic run_burst(input logic [7:0] mask, input logic [DATA_W-1:0] exp);
      wr(OFS_SEL, {16'h0000, mask, EVT_L2_DATA});
      wr(OFS_COUNT, COUNT_RST);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         go <= 1'b1;
         src <= 3'h0;
         ev <= '{valid: 1'b1, is_code: 1'b0, kind: KIND_DEMAND_LOAD, pf_own: 1'b0,
            state: ces_line_t'(i)};
      end
      @(posedge clk);
      go <= 1'b0;
      rd(OFS_COUNT, q);
      chk(q, exp);
   endtask

   task automatic run_halt(input logic [7:0] mask, input int n, input int exp);
      wr(OFS_SEL, {16'h0000, mask, EVT_UNHALT});
      wr(OFS_COUNT, COUNT_RST);
      @(posedge clk);
      halt_in <= 1'b0;
      repeat (n) @(posedge clk);
      halt_in <= 1'b1;
      repeat (4) @(posedge clk);
      rd(OFS_COUNT, q);
      chk(q, DATA_W'(exp));
      rd(OFS_STATUS, q);
      chk(q, 32'h0000_0002);
   endtask

   initial begin
      #20000;
      errors++;
      final_report;
   end

   initial begin
      rst = 1'b1;
      go = 1'b0;
      halt_in = 1'b1;
      src = 3'h0;
      ev = '0;
      bus = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      run_regs;
      run_table;
      run_burst(8'h0f, 32'h0000_0004);
      run_burst(8'h06, 32'h0000_0002);
      run_halt(MASK_THREAD, 13, 13);
      run_halt(MASK_REF, 20, 20 / STAMP_DIV);
      final_report;
   end
endmodule // ces_selector_tb

`default_nettype wire
